/* File: common/ocp_pkg.sv */
// constants and types shared by the output compare / pwm unit
`default_nettype none
package ocp_pkg;
  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_PRIMARY = 8'h08;
  localparam logic [7:0] ADDR_SECONDARY = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // cmp_control_one field positions
  localparam int MODE_LSB = 0;
  localparam int TRIG_CLEAR_BIT = 3;
  localparam int FAULT_EN_LSB = 7;
  localparam int TSEL_LSB = 10;
  // cmp_control_two field positions
  localparam int SYNC_LSB = 0;
  localparam int TRIS_BIT = 5;
  localparam int IRQ_EN_BIT = 6;
  localparam int TRIG_SEL_BIT = 7;
  localparam int CASCADE_BIT = 8;
  localparam int DUTY_LOW_LSB = 9;
  // status register bit positions
  localparam int STAT_IRQ_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_ARMED_BIT = 2;
  localparam int STAT_TRIG_BIT = 3;
  // reset values
  localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
  localparam logic [15:0] CTRL_TWO_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  // sync source codes handled specially
  localparam logic [4:0] SYNC_SELF = 5'h1f;
  localparam logic [4:0] SYNC_NONE = 5'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // compare_mode_field encodings
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_SINGLE_HIGH = 3'h1,
    MODE_SINGLE_LOW = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_DOUBLE_ONE = 3'h4,
    MODE_DOUBLE_CONT = 3'h5,
    MODE_PWM_EDGE = 3'h6,
    MODE_PWM_CENTER = 3'h7
  } ocp_mode_t;
  // pulse sequencer states, gray along idle-armed-active-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_ACTIVE = 2'b11,
    ST_DONE = 2'b10
  } ocp_state_t;
endpackage
`default_nettype wire

/* File: hw/ocp_sync_decode.sv */
// decoder of the sync_source_select field into one source event
`default_nettype none
module ocp_sync_decode
  import ocp_pkg::*;
(
  // selection
  input wire logic [4:0] sel,
  // candidate sources, all single-cycle events
  input wire logic selfEvent,
  input wire logic extTriggerInOne,
  input wire logic extTriggerInTwo,
  input wire logic chargeTimeUnit,
  input wire logic adcEvent,
  input wire logic [2:0] comparatorEvt,
  input wire logic [5:0] captureEvt,
  input wire logic [4:0] timerEvt,
  input wire logic [5:0] cmpUnitEvt,
  // decoded result
  output logic srcEvent,
  output logic srcTriggerOnly
);
  // one bit per code; reserved codes and code zero carry a constant 0
  logic [31:0] eventMap;
  assign eventMap = {selfEvent, extTriggerInOne, extTriggerInTwo,
                     chargeTimeUnit, adcEvent, comparatorEvt,
                     1'b0, captureEvt[5], captureEvt,
                     timerEvt, 4'h0, cmpUnitEvt, 1'b0};
  assign srcEvent = eventMap[sel];
  // capture, comparator, a/d and charge time codes may only trigger
  assign srcTriggerOnly = (sel >= 5'h10) && (sel <= 5'h1c);
endmodule
`default_nettype wire

/* File: hw/ocp_unit.sv */
// output compare / pwm unit with axi4-lite registers
// Function
// - default level, flip on primary match
// - double modes: back on secondary match
// - flag on primary or secondary match
// - single-shot rearmed by control one write
// - edge or center aligned pwm
// - compare values shadowed internally
// - primary is duty, secondary is period
// - clock source in bits twelve to ten
// - duty low bits buffered in pwm
// - fault enable field, pwm modes only, needs irq enable
// - count on selected prescaler tick
// - sync codes 1f down to 18
// - sync codes 16 down to 00
`default_nettype none
module ocp_unit
  import ocp_pkg::*;
#(
  parameter int CW = 16,
  parameter int AW = 8,
  parameter bit IS_ODD = 1'b0
) (
  // clock, reset, clock enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // axi4-lite write channels
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // timer prescaler ticks, one per clock source code
  input wire logic [7:0] timerTick,
  // sync and trigger sources
  input wire logic extTriggerInOne,
  input wire logic extTriggerInTwo,
  input wire logic chargeTimeUnit,
  input wire logic adcEvent,
  input wire logic [2:0] comparatorEvt,
  input wire logic [5:0] captureEvt,
  input wire logic [4:0] timerEvt,
  input wire logic [5:0] cmpUnitEvt,
  // fault inputs
  input wire logic [2:0] faultIn,
  // cascade link to the partner unit
  input wire logic cascadeCarryIn,
  input wire logic cascadePriIn,
  input wire logic cascadeSecIn,
  output logic cascadeCarryOut,
  output logic cascadePriOut,
  output logic cascadeSecOut,
  // pin and status outputs
  output logic cmpOut,
  output logic cmpOutEn,
  output logic compareIrqFlag,
  output logic [1:0] dutyLowBits
);
  // software registers
  logic [15:0] ctrlOneQ, ctrlTwoQ;
  logic [CW-1:0] priQ, secQ;
  // shadow copies used by the comparators and the dutyLowBits output
  logic [CW-1:0] priShQ, secShQ;
  logic [1:0] dutyLowShQ;
  // timer and pulse state
  logic [CW-1:0] cntQ, cntD;
  logic upQ, upD;
  logic outQ, outD;
  logic irqQ, faultQ, trigQ;
  ocp_state_t stQ, stD;
  // bus side state
  logic bvalidQ, rvalidQ;
  logic [1:0] brespQ, rrespQ;
  logic [31:0] rdataQ;

  // field views
  ocp_mode_t mode;
  logic [2:0] tsel, faultEn;
  logic [4:0] syncSel;
  logic trigSel, trigClear, cascade, irqEn;
  assign mode = ocp_mode_t'(ctrlOneQ[MODE_LSB +: 3]);
  assign tsel = ctrlOneQ[TSEL_LSB +: 3];
  assign faultEn = ctrlOneQ[FAULT_EN_LSB +: 3];
  assign trigClear = ctrlOneQ[TRIG_CLEAR_BIT];
  assign syncSel = ctrlTwoQ[SYNC_LSB +: 5];
  assign trigSel = ctrlTwoQ[TRIG_SEL_BIT];
  assign cascade = ctrlTwoQ[CASCADE_BIT];
  assign irqEn = ctrlTwoQ[IRQ_EN_BIT];

  // mode classes
  logic isPwm, isDouble, isSingle, isCenter;
  assign isPwm = (mode == MODE_PWM_EDGE) || (mode == MODE_PWM_CENTER);
  assign isCenter = mode == MODE_PWM_CENTER;
  assign isDouble = mode[2];
  assign isSingle = (mode != MODE_OFF) && !mode[2];

  // bus write decode; address and data are taken together
  logic wrTake, wrHit, wrCtrlOne, wrStatus;
  logic [AW-1:0] wrAddr;
  assign wrTake = awvalid && wvalid && !bvalidQ;
  assign awready = wrTake;
  assign wready = wrTake;
  assign wrAddr = awaddr & ~AW'(3);
  assign wrHit = (wrAddr == AW'(ADDR_CTRL_ONE)) ||
                 (wrAddr == AW'(ADDR_CTRL_TWO)) ||
                 (wrAddr == AW'(ADDR_PRIMARY)) ||
                 (wrAddr == AW'(ADDR_SECONDARY)) ||
                 (wrAddr == AW'(ADDR_COUNT)) ||
                 (wrAddr == AW'(ADDR_STATUS));
  assign wrCtrlOne = wrTake && (wrAddr == AW'(ADDR_CTRL_ONE));
  assign wrStatus = wrTake && (wrAddr == AW'(ADDR_STATUS));
  // byte lanes merged into the low sixteen bits
  logic [15:0] laneMask, wrMerge1, wrMerge2, wrMergeP, wrMergeS;
  assign laneMask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
  assign wrMerge1 = (ctrlOneQ & ~laneMask) | (wdata[15:0] & laneMask);
  assign wrMerge2 = (ctrlTwoQ & ~laneMask) | (wdata[15:0] & laneMask);
  assign wrMergeP = (16'(priQ) & ~laneMask) | (wdata[15:0] & laneMask);
  assign wrMergeS = (16'(secQ) & ~laneMask) | (wdata[15:0] & laneMask);
  // write-one-to-clear strobes for status flags
  logic clrIrq, clrFault;
  assign clrIrq = wrStatus && wstrb[0] && wdata[STAT_IRQ_BIT];
  assign clrFault = wrStatus && wstrb[0] && wdata[STAT_FAULT_BIT];

  // clock source: selected prescaler tick, or partner carry when odd and cascaded
  logic tickSel, running, adv;
  assign tickSel = (cascade && IS_ODD) ? cascadeCarryIn : timerTick[tsel];
  assign running = !trigSel || trigQ;
  assign adv = ce && tickSel && running;

  // comparators; a cascaded pair only matches when both halves do
  logic priEq, secEq, priHit, secHit;
  assign priEq = cntQ == priShQ;
  assign secEq = cntQ == secShQ;
  assign priHit = adv && priEq && (!cascade || cascadePriIn);
  assign secHit = adv && secEq && (!cascade || cascadeSecIn);
  assign cascadePriOut = priEq;
  assign cascadeSecOut = secEq;
  assign cascadeCarryOut = adv && (cntQ == {CW{1'b1}});

  // period end: secondary match going up, or zero on the way down
  logic selfReset, periodEnd;
  assign selfReset = isPwm || (syncSel == SYNC_SELF);
  assign periodEnd = isCenter ? (adv && !upQ && (cntQ == '0))
                              : (secHit && selfReset);

  // sync / trigger source selection
  logic srcEvent, srcTrigOnly, syncReset, trigStart;
  ocp_sync_decode u_decode (
    .sel(syncSel),
    .selfEvent(periodEnd),
    .extTriggerInOne(extTriggerInOne),
    .extTriggerInTwo(extTriggerInTwo),
    .chargeTimeUnit(chargeTimeUnit),
    .adcEvent(adcEvent),
    .comparatorEvt(comparatorEvt),
    .captureEvt(captureEvt),
    .timerEvt(timerEvt),
    .cmpUnitEvt(cmpUnitEvt),
    .srcEvent(srcEvent),
    .srcTriggerOnly(srcTrigOnly)
  );
  // self code already resets via periodEnd; trigger-only codes cannot sync
  assign syncReset = ce && !trigSel && srcEvent && !srcTrigOnly &&
                     (syncSel != SYNC_SELF);
  assign trigStart = ce && trigSel && srcEvent;

  // timer next value
  always_comb begin
    cntD = cntQ;
    upD = upQ;
    if (syncReset || wrCtrlOne) begin
      cntD = '0;
      upD = 1'b1;
    end else if (adv && isCenter) begin
      // center aligned: count up to period, then back to zero
      if (upQ && secEq) begin
        upD = 1'b0;
        cntD = cntQ - CW'(1);
      end else if (!upQ && (cntQ == '0)) begin
        upD = 1'b1;
        cntD = cntQ + CW'(1);
      end else begin
        cntD = upQ ? cntQ + CW'(1) : cntQ - CW'(1);
      end
    end else if (adv) begin
      cntD = periodEnd ? '0 : cntQ + CW'(1);
    end
  end

  // pulse sequencer; single-shot modes end in done until rearmed
  always_comb begin
    stD = stQ;
    unique case (stQ)
      ST_IDLE: stD = ST_IDLE;
      ST_ARMED: begin
        if (priHit && mode != MODE_TOGGLE && !isPwm) begin
          stD = isDouble ? ST_ACTIVE : ST_DONE;
        end
      end
      ST_ACTIVE: begin
        if (secHit) begin
          stD = (mode == MODE_DOUBLE_CONT) ? ST_ARMED : ST_DONE;
        end
      end
      ST_DONE: stD = ST_DONE;
    endcase
    if (wrCtrlOne) begin
      stD = (wrMerge1[MODE_LSB +: 3] == 3'h0) ? ST_IDLE : ST_ARMED;
    end
  end

  // pin level; fault forces the default low level
  logic live, faultNow;
  assign live = stQ != ST_IDLE && stQ != ST_DONE;
  assign faultNow = isPwm && irqEn && |(faultIn & faultEn);
  always_comb begin
    outD = outQ;
    unique case (mode)
      MODE_OFF: outD = 1'b0;
      MODE_SINGLE_HIGH: if (priHit && live) outD = 1'b1;
      MODE_SINGLE_LOW: if (priHit && live) outD = 1'b0;
      MODE_TOGGLE: if (priHit && live) outD = !outQ;
      MODE_DOUBLE_ONE, MODE_DOUBLE_CONT: begin
        if (priHit && stQ == ST_ARMED) outD = 1'b1;
        else if (secHit && stQ == ST_ACTIVE) outD = 1'b0;
      end
      MODE_PWM_EDGE: begin
        if (periodEnd) outD = priShQ != '0;
        else if (priHit) outD = 1'b0;
      end
      MODE_PWM_CENTER: if (priHit) outD = upQ;
    endcase
    // a fresh control one write restores the mode's default level
    if (wrCtrlOne) outD = wrMerge1[MODE_LSB +: 3] == 3'h2;
    if (faultQ || faultNow) outD = 1'b0;
  end

  // software registers; writes land only on mapped words
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlOneQ <= CTRL_ONE_RST;
      ctrlTwoQ <= CTRL_TWO_RST;
      priQ <= CW'(COMPARE_RST);
      secQ <= CW'(COMPARE_RST);
    end else if (ce && wrTake) begin
      if (wrAddr == AW'(ADDR_CTRL_ONE)) ctrlOneQ <= wrMerge1;
      if (wrAddr == AW'(ADDR_CTRL_TWO)) ctrlTwoQ <= wrMerge2;
      if (wrAddr == AW'(ADDR_PRIMARY)) priQ <= CW'(wrMergeP);
      if (wrAddr == AW'(ADDR_SECONDARY)) secQ <= CW'(wrMergeS);
    end
  end

  // shadows: transparent outside pwm, reloaded at period end in pwm
  logic shadowLoad;
  assign shadowLoad = !isPwm || periodEnd || wrCtrlOne;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      priShQ <= CW'(COMPARE_RST);
      secShQ <= CW'(COMPARE_RST);
      dutyLowShQ <= 2'h0;
    end else if (ce && shadowLoad) begin
      priShQ <= priQ;
      secShQ <= secQ;
      dutyLowShQ <= ctrlTwoQ[DUTY_LOW_LSB +: 2];
    end
  end

  // timer, sequencer and pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cntQ <= '0;
      upQ <= 1'b1;
      stQ <= ST_IDLE;
      outQ <= 1'b0;
    end else if (ce) begin
      cntQ <= cntD;
      upQ <= upD;
      stQ <= stD;
      outQ <= outD;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  logic irqSet;
  assign irqSet = (isSingle && priHit) || (isDouble && secHit);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqQ <= 1'b0;
      faultQ <= 1'b0;
      trigQ <= 1'b0;
    end else if (ce) begin
      irqQ <= irqSet || (irqQ && !clrIrq);
      faultQ <= faultNow || (faultQ && !clrFault);
      // trigger holds the timer until started; clear mode stops it again
      trigQ <= trigSel && (trigStart ||
               (trigQ && !(trigClear && periodEnd)));
    end
  end

  // axi write response
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bvalidQ <= 1'b0;
      brespQ <= RESP_OKAY;
    end else if (ce) begin
      if (wrTake) begin
        bvalidQ <= 1'b1;
        brespQ <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalidQ <= 1'b0;
      end
    end
  end

  // axi read path
  logic rdTake;
  logic [AW-1:0] rdAddr;
  logic [15:0] statusWord, rdWord;
  logic rdHit;
  assign rdTake = arvalid && !rvalidQ;
  assign arready = !rvalidQ;
  assign rdAddr = araddr & ~AW'(3);
  assign statusWord = {12'h000, trigQ, live, faultQ, irqQ};
  assign rdHit = (rdAddr == AW'(ADDR_CTRL_ONE)) ||
                 (rdAddr == AW'(ADDR_CTRL_TWO)) ||
                 (rdAddr == AW'(ADDR_PRIMARY)) ||
                 (rdAddr == AW'(ADDR_SECONDARY)) ||
                 (rdAddr == AW'(ADDR_COUNT)) ||
                 (rdAddr == AW'(ADDR_STATUS));
  // shadows have no address: software only sees the written values
  assign rdWord = (rdAddr == AW'(ADDR_CTRL_ONE)) ? ctrlOneQ :
                  (rdAddr == AW'(ADDR_CTRL_TWO)) ? ctrlTwoQ :
                  (rdAddr == AW'(ADDR_PRIMARY)) ? 16'(priQ) :
                  (rdAddr == AW'(ADDR_SECONDARY)) ? 16'(secQ) :
                  (rdAddr == AW'(ADDR_COUNT)) ? 16'(cntQ) :
                  (rdAddr == AW'(ADDR_STATUS)) ? statusWord : 16'h0000;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rvalidQ <= 1'b0;
      rrespQ <= RESP_OKAY;
      rdataQ <= 32'h0000_0000;
    end else if (ce) begin
      if (rdTake) begin
        rvalidQ <= 1'b1;
        rrespQ <= rdHit ? RESP_OKAY : RESP_SLVERR;
        rdataQ <= {16'h0000, rdWord};
      end else if (rready) begin
        rvalidQ <= 1'b0;
      end
    end
  end

  // outputs
  assign bvalid = bvalidQ;
  assign bresp = brespQ;
  assign rvalid = rvalidQ;
  assign rresp = rrespQ;
  assign rdata = rdataQ;
  assign cmpOut = outQ;
  assign cmpOutEn = !ctrlTwoQ[TRIS_BIT];
  assign compareIrqFlag = irqQ;
  assign dutyLowBits = dutyLowShQ;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_arm_hit;
    ce && !wrCtrlOne && stQ == ST_ARMED && priHit;
  endsequence
  chk_pri_rise: assert property (
    s_arm_hit and (mode == MODE_SINGLE_HIGH && !faultNow && !faultQ)
    |=> cmpOut)
    else $error("primary match did not raise the pin");
  chk_sec_fall: assert property (
    ce && !wrCtrlOne && isDouble && stQ == ST_ACTIVE && secHit
    |=> !cmpOut)
    else $error("secondary match did not restore the pin");
  chk_irq_source: assert property (
    ce && $rose(irqQ) |-> $past(irqSet))
    else $error("compare flag set without a qualifying match");
  chk_oneshot_done: assert property (
    stQ == ST_DONE && !wrCtrlOne |=> stQ == ST_DONE)
    else $error("single-shot pulse repeated without rearm");
  chk_edge_wrap: assert property (
    ce && mode == MODE_PWM_EDGE && secHit && !wrCtrlOne && !syncReset
    |=> cntQ == '0)
    else $error("edge pwm period did not wrap");
  chk_center_turn: assert property (
    ce && isCenter && adv && upQ && secEq && !wrCtrlOne && !syncReset
    |=> !upQ ##0 cntQ == $past(cntQ) - CW'(1))
    else $error("center pwm did not turn at period");
  chk_shadow_hold: assert property (
    ce && isPwm && !periodEnd && !wrCtrlOne |=> $stable(priShQ) &&
    $stable(secShQ))
    else $error("pwm shadow changed mid period");
  chk_duty_low: assert property (
    ce && isPwm && !periodEnd && !wrCtrlOne |=> $stable(dutyLowBits))
    else $error("duty low bits changed mid period");
  chk_tick_gate: assert property (
    !adv && !syncReset && !wrCtrlOne |=> $stable(cntQ))
    else $error("timer moved without a selected tick");
  chk_fault_low: assert property (
    ce && faultNow |=> !cmpOut [*2])
    else $error("fault did not hold the pin low");
endmodule
`default_nettype wire

/* File: test/tb_output_compare_pwm_unit.sv */
// self-checking bench for the output compare / pwm unit
`default_nettype none
module tb_output_compare_pwm_unit
  import ocp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // bench clock, reset and bus drive
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [7:0] timerTick = 8'hff;
  logic [23:0] evt = 24'h0; // all trigger/sync sources but self, one bit each
  logic [2:0] faultIn = 3'h0;
  // partner half equal levels, only read while cascade is set
  logic casPri = 1'b0, casSec = 1'b0;
  // dut outputs
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp, dutyLowBits;
  wire logic [31:0] rdata;
  wire logic cmpOut, cmpOutEn, compareIrqFlag;
  // bookkeeping
  int errCount = 0;
  int numChecks = 0;
  logic [1:0] lastB, lastResp;
  logic [31:0] lastR;
  int h, r;
  `define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errCount++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
  always #2.5 ref_clk = ~ref_clk;
  ocp_unit dut_u (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timerTick(timerTick), .extTriggerInOne(evt[0]),
    .extTriggerInTwo(evt[1]), .chargeTimeUnit(evt[2]), .adcEvent(evt[3]),
    .comparatorEvt(evt[6:4]), .captureEvt(evt[12:7]),
    .timerEvt(evt[17:13]), .cmpUnitEvt(evt[23:18]), .faultIn(faultIn),
    .cascadeCarryIn(1'b0), .cascadePriIn(casPri), .cascadeSecIn(casSec),
    .cascadeCarryOut(), .cascadePriOut(), .cascadeSecOut(),
    .cmpOut(cmpOut), .cmpOutEn(cmpOutEn), .compareIrqFlag(compareIrqFlag),
    .dutyLowBits(dutyLowBits));
  // the single place where the run ends
  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic timeoutHit();
    errCount++;
    finalReport();
  endtask
  // sample settled values at negedge, bounded so a dead slave ends the run
  `define WAITHI(s) begin n = 0; do begin @(negedge ref_clk); n++; end \
    while ((s) !== 1'b1 && n < 50); if ((s) !== 1'b1) timeoutHit(); end
  // axi4-lite write: address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    awaddr <= a; wdata <= {16'h0, d}; wstrb <= 4'h3;
    awvalid <= 1'b1; wvalid <= 1'b1;
    `WAITHI(awready && wready)
    @(posedge ref_clk);
    awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b1;
    `WAITHI(bvalid)
    lastB = bresp;
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask
  // axi4-lite read, data kept in lastR and lastResp
  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a; arvalid <= 1'b1;
    `WAITHI(arready)
    @(posedge ref_clk);
    arvalid <= 1'b0; rready <= 1'b1;
    `WAITHI(rvalid)
    lastR = rdata; lastResp = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask
  task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(lastResp, RESP_OKAY)
    `CHK(lastR, e)
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // wait for the pin to reach a level, bounded
  task automatic waitOut(input logic v);
    int n;
    `WAITHI(cmpOut === v)
    @(posedge ref_clk);
    numChecks++;
  endtask
  // count high samples and rising edges of the pin over a window
  task automatic highs(input int len, output int hi, output int ri);
    logic p;
    hi = 0; ri = 0; p = cmpOut;
    repeat (len) begin
      @(negedge ref_clk);
      hi += (cmpOut === 1'b1);
      ri += (cmpOut === 1'b1 && p === 1'b0);
      p = cmpOut;
    end
    @(posedge ref_clk);
  endtask
  task automatic pulse(input logic [23:0] v);
    evt <= v;
    @(posedge ref_clk);
    evt <= 24'h0;
  endtask
  // sync code for each source bit of evt
  function automatic logic [4:0] codeOf(input int b);
    if (b < 4) return 5'h1e - 5'(b);
    if (b < 7) return 5'h18 + 5'(b - 4);
    if (b < 13) return 5'h10 + 5'(b - 7);
    if (b < 18) return 5'h0b + 5'(b - 13);
    return 5'h01 + 5'(b - 18);
  endfunction
  // hang guard beside the bounded waits
  initial begin
    repeat (100000) @(posedge ref_clk);
    timeoutHit();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    `CHK(cmpOut, 1'b0)
    `CHK(cmpOutEn, 1'b1)
    chkRd(ADDR_CTRL_ONE, 32'h0);
    chkRd(ADDR_STATUS, 32'h0);
    rd(8'h18);
    `CHK(lastResp, RESP_SLVERR)
    wr(8'h18, 16'h1234);
    `CHK(lastB, RESP_SLVERR)
    wr(ADDR_CTRL_TWO, 16'h0520);
    chkRd(ADDR_CTRL_TWO, 32'h0520);
    `CHK(cmpOutEn, 1'b0)
    `CHK(dutyLowBits, 2'b10)
    $display("test registers done");
    // single compare, high then low default, flag, one shot, rearm
    wr(ADDR_CTRL_TWO, 16'h0000);
    `CHK(cmpOutEn, 1'b1)
    wr(ADDR_PRIMARY, 16'h000a);
    wr(ADDR_CTRL_ONE, 16'h0001);
    `CHK(cmpOut, 1'b0)
    waitOut(1'b1);
    `CHK(compareIrqFlag, 1'b1)
    highs(60, h, r);
    `CHK(r, 0)
    rd(ADDR_STATUS);
    `CHK(lastR[STAT_IRQ_BIT], 1'b1)
    wr(ADDR_STATUS, 16'h0001);
    `CHK(compareIrqFlag, 1'b0)
    wr(ADDR_CTRL_ONE, 16'h0001);
    `CHK(cmpOut, 1'b0)
    waitOut(1'b1);
    wr(ADDR_CTRL_ONE, 16'h0002);
    `CHK(cmpOut, 1'b1)
    waitOut(1'b0);
    $display("test single compare done");
    // double compare one shot and continuous
    wr(ADDR_STATUS, 16'h0001);
    wr(ADDR_PRIMARY, 16'h0005);
    wr(ADDR_SECONDARY, 16'h000c);
    wr(ADDR_CTRL_ONE, 16'h0004);
    waitOut(1'b1);
    `CHK(compareIrqFlag, 1'b0)
    waitOut(1'b0);
    @(posedge ref_clk);
    `CHK(compareIrqFlag, 1'b1)
    highs(60, h, r);
    `CHK(r, 0)
    wr(ADDR_CTRL_TWO, 16'h001f);
    wr(ADDR_CTRL_ONE, 16'h0005);
    highs(60, h, r);
    `CHK(r >= 4, 1'b1)
    // toggle mode: one flip per self-synced period of six
    wr(ADDR_PRIMARY, 16'h0002);
    wr(ADDR_SECONDARY, 16'h0005);
    wr(ADDR_CTRL_ONE, 16'h0003);
    highs(12, h, r);
    `CHK(h, 6)
    $display("test double compare done");
    // edge pwm: primary 2 gives 3 of 6 cycles high, shadowed change to 4 gives 5
    wr(ADDR_PRIMARY, 16'h0002);
    wr(ADDR_SECONDARY, 16'h0005);
    wr(ADDR_CTRL_ONE, 16'h0006);
    cyc(20);
    highs(12, h, r);
    `CHK(h, 6)
    wr(ADDR_PRIMARY, 16'h0004);
    chkRd(ADDR_PRIMARY, 32'h0004);
    cyc(12);
    highs(12, h, r);
    `CHK(h, 10)
    wr(ADDR_SECONDARY, 16'h00c8);
    cyc(10);
    wr(ADDR_CTRL_TWO, 16'h061f);
    `CHK(dutyLowBits, 2'b00)
    cyc(210);
    `CHK(dutyLowBits, 2'b11)
    $display("test edge pwm done");
    // center pwm, then fault with and without irq enable
    wr(ADDR_PRIMARY, 16'h0002);
    wr(ADDR_SECONDARY, 16'h0005);
    wr(ADDR_CTRL_TWO, 16'h005f);
    wr(ADDR_CTRL_ONE, 16'h0087);
    cyc(25);
    highs(20, h, r);
    `CHK(h, 12)
    faultIn <= 3'b001;
    cyc(3);
    highs(20, h, r);
    `CHK(h, 0)
    rd(ADDR_STATUS);
    `CHK(lastR[STAT_FAULT_BIT], 1'b1)
    wr(ADDR_CTRL_TWO, 16'h001f);
    wr(ADDR_STATUS, 16'h0002);
    wr(ADDR_CTRL_ONE, 16'h0087);
    cyc(25);
    highs(20, h, r);
    `CHK(h, 12)
    faultIn <= 3'b000;
    $display("test pwm and fault done");
    // clock source select: only the chosen tick advances the count
    wr(ADDR_CTRL_TWO, 16'h0000);
    wr(ADDR_PRIMARY, 16'h0003);
    timerTick <= 8'hdf;
    wr(ADDR_CTRL_ONE, 16'h1401);
    chkRd(ADDR_CTRL_ONE, 32'h1401);
    cyc(20);
    `CHK(cmpOut, 1'b0)
    timerTick <= 8'hff;
    waitOut(1'b1);
    $display("test clock source done");
    // even half of a pair: no match until the partner half agrees
    wr(ADDR_CTRL_TWO, 16'h011f);
    casSec <= 1'b1;
    wr(ADDR_CTRL_ONE, 16'h0001);
    cyc(20);
    `CHK(cmpOut, 1'b0)
    casPri <= 1'b1;
    waitOut(1'b1);
    // external sync keeps restarting the count below the primary
    wr(ADDR_CTRL_TWO, 16'h001e);
    wr(ADDR_PRIMARY, 16'h0008);
    wr(ADDR_CTRL_ONE, 16'h0001);
    repeat (4) begin
      cyc(5);
      pulse(24'h1);
    end
    `CHK(cmpOut, 1'b0)
    waitOut(1'b1);
    $display("test cascade and sync done");
    // triggered start from every source on evt, others ignored
    wr(ADDR_PRIMARY, 16'h0001);
    for (int b = 0; b < 24; b++) begin
      // trigger select off drops the start held from the last source
      wr(ADDR_CTRL_TWO, 16'h0000);
      wr(ADDR_CTRL_TWO, 16'h0080 | 16'(codeOf(b)));
      wr(ADDR_CTRL_ONE, 16'h0001);
      cyc(6);
      `CHK(cmpOut, 1'b0)
      pulse(~(24'h1 << b));
      cyc(6);
      `CHK(cmpOut, 1'b0)
      pulse(24'h1 << b);
      waitOut(1'b1);
    end
    $display("test sync decode done");
    finalReport();
  end
endmodule
`default_nettype wire
